// [verilog/codec_ctrl_pkg.sv]
/*
 codec control register bank package: addresses, field positions, reset values.
 assumes a 16-bit control word: 7 address bits above 9 data bits.
*/
package codec_ctrl_pkg;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 9;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 9;
	localparam int NUM_REGS = 8;
	localparam logic [6:0] left_line_input_ctrl = 7'h00;
	localparam logic [6:0] right_line_input_ctrl = 7'h01;
	localparam logic [6:0] analogue_path_ctrl = 7'h04;
	localparam logic [6:0] digital_path_ctrl = 7'h05;
	localparam int GAIN_LSB = 0;
	localparam int SILENCE_BIT = 7;
	localparam int COPY_BIT = 8;
	localparam int DAC_SEL_BIT = 4;
	localparam int HIGHPASS_BIT = 0;
	localparam int DEEMPH_LSB = 1;
	localparam int DAC_SILENCE_BIT = 3;
	localparam int OFFSET_HOLD_BIT = 4;
	localparam logic [4:0] GAIN_RESET = 5'h17;
	localparam logic SILENCE_RESET = 1'b1;
	localparam logic DAC_SEL_RESET = 1'b0;
	localparam logic HIGHPASS_RESET = 1'b0;
	localparam logic [1:0] DEEMPH_RESET = 2'h0;
	localparam logic DAC_SILENCE_RESET = 1'b1;
	localparam logic OFFSET_HOLD_RESET = 1'b0;
	localparam logic [1:0] DEEMPH_OFF = 2'h0;
	localparam logic [1:0] DEEMPH_32K = 2'h1;
	localparam logic [1:0] DEEMPH_44K1 = 2'h2;
	localparam logic [1:0] DEEMPH_48K = 2'h3;
endpackage

// [verilog/codec_ctrl_regs.sv]
/*
 codec input and path control register bank, written by 16-bit control words.
 assumes the serial front end delivers each decoded word as a one-cycle strobe
 synchronous to sys_clk_in.
*/
// Operation
// - four nine-bit registers, serially writable
// - left gain five bits, resets to 0dB
// - right gain bits 4:0, same code
// - left bit 7 mutes left input
// - right bit 7 mutes right input
// - left write bit 8 copies to right
// - right write bit 8 copies to left
// - analogue bit 4 selects DAC output
// - highpass enable and de-emphasis select
// - digital bit 3 soft-mutes DAC
// - digital bit 4 holds dc offset
// - word: address 15:9, data 8:0
`timescale 1ns/10ps
module codec_ctrl_regs
	import codec_ctrl_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic wr_strobe_in,
	input wire logic [codec_ctrl_pkg::WORD_W-1:0] wr_word_in,
	output logic [4:0] left_in_gain_out,
	output logic left_in_silence_out,
	output logic [4:0] right_in_gain_out,
	output logic right_in_silence_out,
	output logic dac_to_output_out,
	output logic adc_highpass_on_out,
	output logic [1:0] deemph_rate_sel_out,
	output logic dac_soft_silence_out,
	output logic highpass_offset_hold_out
);
	import codec_ctrl_pkg::*;

	typedef struct packed {
		logic [4:0] left_in_gain;
		logic left_in_silence;
		logic [4:0] right_in_gain;
		logic right_in_silence;
		logic dac_to_output;
		logic adc_highpass_on;
		logic [1:0] deemph_rate_sel;
		logic dac_soft_silence;
		logic highpass_offset_hold;
	} regs_s;

	regs_s state_q;
	regs_s state_d;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data;

	// in_bank lists this bank's addresses for the foreign-write check; the write case decodes them separately; the rest of the map lives elsewhere
	function automatic logic in_bank(input logic [ADDR_W-1:0] reg_addr);
		in_bank = (reg_addr == left_line_input_ctrl) || (reg_addr == right_line_input_ctrl)
			|| (reg_addr == analogue_path_ctrl) || (reg_addr == digital_path_ctrl);
	endfunction

	function automatic regs_s reset_image();
		regs_s img;
		img.left_in_gain = GAIN_RESET;
		img.left_in_silence = SILENCE_RESET;
		img.right_in_gain = GAIN_RESET;
		img.right_in_silence = SILENCE_RESET;
		img.dac_to_output = DAC_SEL_RESET;
		img.adc_highpass_on = HIGHPASS_RESET;
		img.deemph_rate_sel = DEEMPH_RESET;
		img.dac_soft_silence = DAC_SILENCE_RESET;
		img.highpass_offset_hold = OFFSET_HOLD_RESET;
		return img;
	endfunction

	// the copy bits are write actions only; they are not stored in state_q
	assign addr = wr_word_in[ADDR_MSB:ADDR_LSB];
	assign data = wr_word_in[DATA_W-1:0];

	always_comb
	begin
		state_d = state_q;
		if (wr_strobe_in)
		begin
			// bits without a function are dropped; host keeps them zero
			unique case (addr)
				left_line_input_ctrl:
				begin
					state_d.left_in_gain = data[GAIN_LSB +: 5];
					state_d.left_in_silence = data[SILENCE_BIT];
					if (data[COPY_BIT])
					begin
						state_d.right_in_gain = data[GAIN_LSB +: 5];
						state_d.right_in_silence = data[SILENCE_BIT];
					end
				end
				right_line_input_ctrl:
				begin
					state_d.right_in_gain = data[GAIN_LSB +: 5];
					state_d.right_in_silence = data[SILENCE_BIT];
					if (data[COPY_BIT])
					begin
						state_d.left_in_gain = data[GAIN_LSB +: 5];
						state_d.left_in_silence = data[SILENCE_BIT];
					end
				end
				analogue_path_ctrl:
					state_d.dac_to_output = data[DAC_SEL_BIT];
				digital_path_ctrl:
				begin
					state_d.adc_highpass_on = data[HIGHPASS_BIT];
					state_d.deemph_rate_sel = data[DEEMPH_LSB +: 2];
					state_d.dac_soft_silence = data[DAC_SILENCE_BIT];
					state_d.highpass_offset_hold = data[OFFSET_HOLD_BIT];
				end
				// registers outside this bank and unmapped addresses change nothing here
				default: state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (srst_in)
		begin
			state_q.left_in_gain <= GAIN_RESET;
			state_q.left_in_silence <= SILENCE_RESET;
			state_q.right_in_gain <= GAIN_RESET;
			state_q.right_in_silence <= SILENCE_RESET;
			state_q.dac_to_output <= DAC_SEL_RESET;
			state_q.adc_highpass_on <= HIGHPASS_RESET;
			state_q.deemph_rate_sel <= DEEMPH_RESET;
			state_q.dac_soft_silence <= DAC_SILENCE_RESET;
			state_q.highpass_offset_hold <= OFFSET_HOLD_RESET;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign left_in_gain_out = state_q.left_in_gain;
	assign left_in_silence_out = state_q.left_in_silence;
	assign right_in_gain_out = state_q.right_in_gain;
	assign right_in_silence_out = state_q.right_in_silence;
	assign dac_to_output_out = state_q.dac_to_output;
	assign adc_highpass_on_out = state_q.adc_highpass_on;
	assign deemph_rate_sel_out = state_q.deemph_rate_sel;
	assign dac_soft_silence_out = state_q.dac_soft_silence;
	assign highpass_offset_hold_out = state_q.highpass_offset_hold;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);

	sequence left_copy_wr_s;
		wr_strobe_in && wr_word_in[ADDR_MSB:ADDR_LSB] == left_line_input_ctrl
			&& wr_word_in[COPY_BIT];
	endsequence

	sequence right_copy_wr_s;
		wr_strobe_in && wr_word_in[ADDR_MSB:ADDR_LSB] == right_line_input_ctrl
			&& wr_word_in[COPY_BIT];
	endsequence

	sequence left_wr_s;
		wr_strobe_in && addr == left_line_input_ctrl;
	endsequence

	sequence right_wr_s;
		wr_strobe_in && addr == right_line_input_ctrl;
	endsequence

	sequence analogue_wr_s;
		wr_strobe_in && addr == analogue_path_ctrl;
	endsequence

	sequence digital_wr_s;
		wr_strobe_in && addr == digital_path_ctrl;
	endsequence

	sequence left_plain_wr_s;
		wr_strobe_in && addr == left_line_input_ctrl && !wr_word_in[COPY_BIT];
	endsequence

	sequence right_plain_wr_s;
		wr_strobe_in && addr == right_line_input_ctrl && !wr_word_in[COPY_BIT];
	endsequence

	// a write that misses the bank, whether to another device register or to nothing
	sequence foreign_wr_s;
		wr_strobe_in && !in_bank(addr);
	endsequence

	sequence reset_and_wr_s;
		srst_in && wr_strobe_in;
	endsequence

	left_gain_wr_a: assert property (wr_strobe_in && addr == left_line_input_ctrl |=>
		left_in_gain_out == $past(wr_word_in[GAIN_LSB +: 5]))
		else $error("left gain not loaded");
	left_mute_wr_a: assert property (wr_strobe_in && addr == left_line_input_ctrl |=>
		left_in_silence_out == $past(wr_word_in[SILENCE_BIT]))
		else $error("left mute not loaded");
	right_mute_wr_a: assert property (wr_strobe_in && addr == right_line_input_ctrl |=>
		right_in_silence_out == $past(wr_word_in[SILENCE_BIT])
		&& right_in_gain_out == $past(wr_word_in[GAIN_LSB +: 5]))
		else $error("right channel not loaded");
	left_copy_a: assert property (left_copy_wr_s |=>
		right_in_gain_out == left_in_gain_out && right_in_silence_out == left_in_silence_out)
		else $error("left to right copy missing");
	right_copy_a: assert property (right_copy_wr_s |=>
		left_in_gain_out == right_in_gain_out && left_in_silence_out == right_in_silence_out)
		else $error("right to left copy missing");
	no_copy_a: assert property (wr_strobe_in && addr == left_line_input_ctrl
		&& !wr_word_in[COPY_BIT] |=> $stable(right_in_gain_out))
		else $error("right gain changed without copy");
	dac_sel_wr_a: assert property (wr_strobe_in && addr == analogue_path_ctrl |=>
		dac_to_output_out == $past(wr_word_in[DAC_SEL_BIT]))
		else $error("dac select not loaded");
	deemph_wr_a: assert property (wr_strobe_in && addr == digital_path_ctrl |=>
		deemph_rate_sel_out == $past(wr_word_in[DEEMPH_LSB +: 2])
		&& adc_highpass_on_out == $past(wr_word_in[HIGHPASS_BIT]))
		else $error("digital path filter fields not loaded");
	dac_mute_wr_a: assert property (wr_strobe_in && addr == digital_path_ctrl |=>
		dac_soft_silence_out == $past(wr_word_in[DAC_SILENCE_BIT])
		&& highpass_offset_hold_out == $past(wr_word_in[OFFSET_HOLD_BIT]))
		else $error("digital path mute or hold not loaded");
	idle_hold_a: assert property (!wr_strobe_in |=> $stable(state_q))
		else $error("state changed without a write");
	reset_vals_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		srst_in |=> left_in_gain_out == GAIN_RESET && dac_soft_silence_out
		&& left_in_silence_out && right_in_silence_out && !dac_to_output_out)
		else $error("reset defaults wrong");

	// each write may touch only its own fields, plus the partner channel on a copy
	right_gain_wr_a: assert property (right_wr_s |=>
		right_in_gain_out == $past(wr_word_in[GAIN_LSB +: 5]))
		else $error("right gain not loaded");
	copy_gain_val_a: assert property (left_copy_wr_s |=>
		right_in_gain_out == $past(wr_word_in[GAIN_LSB +: 5]))
		else $error("left gain not copied to right");
	copy_mute_val_a: assert property (left_copy_wr_s |=>
		right_in_silence_out == $past(wr_word_in[SILENCE_BIT]))
		else $error("left mute not copied to right");
	back_gain_val_a: assert property (right_copy_wr_s |=>
		left_in_gain_out == $past(wr_word_in[GAIN_LSB +: 5]))
		else $error("right gain not copied to left");
	back_mute_val_a: assert property (right_copy_wr_s |=>
		left_in_silence_out == $past(wr_word_in[SILENCE_BIT]))
		else $error("right mute not copied to left");
	no_copy_mute_a: assert property (left_plain_wr_s |=>
		$stable(right_in_silence_out))
		else $error("right mute changed without copy");
	left_kept_a: assert property (right_plain_wr_s |=>
		$stable(left_in_gain_out) && $stable(left_in_silence_out))
		else $error("left channel changed without copy");
	foreign_hold_a: assert property (foreign_wr_s |=> $stable(state_q))
		else $error("write outside the bank changed state");
	left_line_only_a: assert property (left_wr_s |=>
		$stable(dac_to_output_out) && $stable(adc_highpass_on_out)
		&& $stable(deemph_rate_sel_out) && $stable(dac_soft_silence_out)
		&& $stable(highpass_offset_hold_out))
		else $error("left line write touched a path field");
	right_line_only_a: assert property (right_wr_s |=>
		$stable(dac_to_output_out) && $stable(adc_highpass_on_out)
		&& $stable(deemph_rate_sel_out) && $stable(dac_soft_silence_out)
		&& $stable(highpass_offset_hold_out))
		else $error("right line write touched a path field");
	analogue_only_a: assert property (analogue_wr_s |=>
		$stable(left_in_gain_out) && $stable(left_in_silence_out)
		&& $stable(right_in_gain_out) && $stable(right_in_silence_out)
		&& $stable(adc_highpass_on_out) && $stable(deemph_rate_sel_out)
		&& $stable(dac_soft_silence_out) && $stable(highpass_offset_hold_out))
		else $error("analogue write touched another field");
	digital_only_a: assert property (digital_wr_s |=>
		$stable(left_in_gain_out) && $stable(left_in_silence_out)
		&& $stable(right_in_gain_out) && $stable(right_in_silence_out)
		&& $stable(dac_to_output_out))
		else $error("digital write touched another field");
	hp_enable_wr_a: assert property (digital_wr_s |=>
		adc_highpass_on_out == $past(wr_word_in[HIGHPASS_BIT]))
		else $error("highpass enable not loaded");
	offset_hold_wr_a: assert property (digital_wr_s |=>
		highpass_offset_hold_out == $past(wr_word_in[OFFSET_HOLD_BIT]))
		else $error("offset hold not loaded");

	// reset checks use reset itself as the trigger, so they override the default disable with disable iff (1'b0)
	reset_wins_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		reset_and_wr_s |=> state_q == reset_image())
		else $error("write taken during reset");
	reset_image_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		srst_in |=> state_q == reset_image())
		else $error("reset image wrong");
	reset_right_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		srst_in |=> right_in_gain_out == GAIN_RESET)
		else $error("right gain reset wrong");
	mute_reset_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		srst_in |=> left_in_silence_out == SILENCE_RESET
		&& right_in_silence_out == SILENCE_RESET)
		else $error("input mute reset wrong");
	reset_filter_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		srst_in |=> adc_highpass_on_out == HIGHPASS_RESET
		&& deemph_rate_sel_out == DEEMPH_RESET)
		else $error("filter reset wrong");
	reset_hold_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		srst_in |=> highpass_offset_hold_out == OFFSET_HOLD_RESET)
		else $error("offset hold reset wrong");
	dac_mute_rst_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
		srst_in |=> dac_soft_silence_out == DAC_SILENCE_RESET
		&& dac_to_output_out == DAC_SEL_RESET)
		else $error("dac mute or select reset wrong");
endmodule

// [test/codec_host_model.sv]
/*
 host model: issues 16-bit control words as one-cycle strobes.
 assumes the bench calls send only after reset is released.
*/
`timescale 1ns/10ps
module codec_host_model
(
	input wire logic sys_clk_in,
	output logic wr_strobe_out,
	output logic [15:0] wr_word_out
);
	initial
	begin
		wr_strobe_out = 1'b0;
		wr_word_out = 16'h0000;
	end
	// strobe held up, so back-to-back sends give one word per cycle
	task automatic send(input logic [6:0] addr, input logic [8:0] data);
		@(posedge sys_clk_in);
		wr_strobe_out <= 1'b1;
		wr_word_out <= {addr, data};
	endtask
	// released word flips so stale data never looks valid
	task automatic idle();
		@(posedge sys_clk_in);
		wr_strobe_out <= 1'b0;
		wr_word_out <= ~wr_word_out;
	endtask
endmodule

// [test/codec_ctrl_regs_tb.sv]
/*
 bench for the codec control register bank: table of writes, then hand cases.
 assumes the host model drives the write port; unused data bits are zero.
*/
`timescale 1ns/10ps
module codec_ctrl_regs_tb;
	import codec_ctrl_pkg::*;
	typedef struct packed {logic [6:0] a; logic [8:0] d; logic [17:0] e;} row_s;
	logic sys_clk_in;
	logic srst_in;
	wire logic wr_strobe;
	wire logic [15:0] wr_word;
	wire logic [4:0] lg, rg;
	wire logic ls, rs, dac, hp, dsm, hold;
	wire logic [1:0] de;
	wire logic [17:0] outs = {lg, ls, rg, rs, dac, hp, de, dsm, hold};
	int fails = 0;
	int n_compared = 0;
	// expected outputs accumulate row by row; unused bits written as zero
	row_s rows [13] = '{
		'{7'h00, 9'h01f, 18'h3ebc2},
		'{7'h01, 9'h000, 18'h3e002},
		'{7'h00, 9'h185, 18'h0b2c2},
		'{7'h01, 9'h11a, 18'h34d02},
		'{7'h04, 9'h010, 18'h34d22},
		'{7'h05, 9'h001, 18'h34d30},
		'{7'h05, 9'h002, 18'h34d24},
		'{7'h05, 9'h004, 18'h34d28},
		'{7'h05, 9'h006, 18'h34d2c},
		'{7'h05, 9'h018, 18'h34d23},
		'{7'h02, 9'h1ff, 18'h34d23},
		'{7'h04, 9'h000, 18'h34d03},
		'{7'h45, 9'h000, 18'h34d03}
	};
	codec_host_model codec_host_model_i (.sys_clk_in(sys_clk_in), .wr_strobe_out(wr_strobe),
		.wr_word_out(wr_word));
	codec_ctrl_regs codec_ctrl_regs_i (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
		.wr_strobe_in(wr_strobe), .wr_word_in(wr_word), .left_in_gain_out(lg),
		.left_in_silence_out(ls), .right_in_gain_out(rg), .right_in_silence_out(rs),
		.dac_to_output_out(dac), .adc_highpass_on_out(hp), .deemph_rate_sel_out(de),
		.dac_soft_silence_out(dsm), .highpass_offset_hold_out(hold));
	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	task automatic check(input logic [17:0] exp);
		@(negedge sys_clk_in);
		n_compared++;
		if (outs !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, outs, exp);
		end
	endtask
	task automatic print_verdict();
		if (fails == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		srst_in = 1'b1;
		repeat (4) @(posedge sys_clk_in);
		srst_in <= 1'b0;
		check(18'h2fbc2);
		foreach (rows[i])
		begin
			codec_host_model_i.send(rows[i].a, rows[i].d);
			codec_host_model_i.idle();
			check(rows[i].e);
		end
		// back-to-back words, one per cycle
		codec_host_model_i.send(7'h00, 9'h003);
		codec_host_model_i.send(7'h01, 9'h09f);
		codec_host_model_i.idle();
		check(18'h06fc3);
		// reset must win over a write taken at the same edge
		codec_host_model_i.send(7'h04, 9'h010);
		srst_in <= 1'b1;
		codec_host_model_i.idle();
		srst_in <= 1'b0;
		check(18'h2fbc2);
		print_verdict();
	end
	initial
	begin
		repeat (2000) @(posedge sys_clk_in);
		fails++;
		print_verdict();
	end
endmodule
